// ===== logic/mbf_loader.sv
// Multi-image boot loader with version fallback, watchdog and warm restart
//
// Function
// RL1 - Flash clock is programmable, default 2.99MHz, capped 15.38MHz low or 40MHz high.
// RL2 - Power-up fetches image zero from flash address 0.
// RL3 - Configuration error resets all but fallback logic, then reloads older image.
// RL4 - Failing fallback image drops error flag low and raises flash select.
// RL5 - Images used for multi-booting must enable the watchdog.
// RL6 - ID mismatch, CRC error, watchdog timeout or authentication failure start fallback.
// RL7 - Warm restart loads from the warm restart address register.
// RL8 - Failed application falls back to golden image or previous good image.
// RL9 - Commands are ignored until the synchronisation word is seen.
// RL10 - Host precedes the stream with padding and bus-width detection words.
// RL11 - Address write is omitted when the golden image already set it.
// RL12 - Without golden image the host writes the start address.
// RL13 - Address header is followed by one word stored as restart address.
// RL14 - Command header with warm restart value starts a warm restart.
// RL15 - Host ends with release command and 100 no-operation words.
// RL16 - Warm restart without address write clears configuration memory.
// RL17 - Watchdog decrements once per configuration clock, flags timeout at zero.
// RL18 - Enabled watchdog timeout during master flash loading starts fallback.
// RL19 - Watchdog stays off during and after fallback until a warm restart.
// RL20 - Watchdog load value exceeds image length over bus width.
// RL21 - Host issues warm restart over JTAG or internal parallel port.
// RL22 - Host checks wake-complete before JTAG readback.
// RL23 - Sticky fallback record makes a second failure end configuration.
// RL24 - Watchdog loads its start value at load start or warm restart.
`timescale 1ns/100ps
module mbf_loader
   import mbf_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Flash clock and master mode settings
   input wire logic high_speed_mode,
   input wire logic [7:0] cfg_clk_period,
   input wire logic spi_master_mode,
   // Image settings for the watchdog
   input wire logic wd_enable,
   input wire logic [31:0] wd_load_value,
   // Command word stream
   input wire logic cmd_valid,
   input wire logic [31:0] cmd_word,
   // Load progress and errors
   input wire logic load_done,
   input wire logic id_mismatch,
   input wire logic crc_error,
   input wire logic auth_fail,
   // Flash pins
   output logic flash_select_low,
   output logic flash_clk,
   // Load requests
   output logic load_start_q,
   output logic [31:0] load_addr_q,
   output logic cfg_reset_q,
   output logic mem_clear_q,
   // Status
   output logic config_error_low,
   output logic user_mode,
   output logic fallback_active,
   output logic wd_timeout_q,
   output logic [31:0] warm_restart_address_reg
);
   // ---------------------------------------------------------------
   // Flash clock
   // ---------------------------------------------------------------
   logic [7:0] per_min;
   logic [7:0] per_eff;
   logic sck;
   logic cfg_tick;

   assign per_min = high_speed_mode ? PER_HIGH_MIN : PER_LOW_MIN;
   assign per_eff = (cfg_clk_period == PER_ZERO) ? PER_DEFAULT :
                    (cfg_clk_period < per_min) ? per_min : cfg_clk_period; // RL1

   mbf_clkdiv u_div (
      .clk(clk),
      .reset(reset),
      .period(per_eff),
      .sck_q(sck),
      .tick_q(cfg_tick)
   );

   // ---------------------------------------------------------------
   // Command stream parser
   // ---------------------------------------------------------------
   mbf_parse_t ps_q;
   mbf_parse_t ps_d;
   logic addr_written_q;
   logic warm_cmd;
   logic addr_take;

   assign addr_take = cmd_valid && (ps_q == PS_ADDR_DATA);
   assign warm_cmd = cmd_valid && (ps_q == PS_CMD_DATA) && (cmd_word == W_CMD_WARM_RESTART); // RL14

   always_comb begin
      ps_d = ps_q;
      if (cmd_valid) begin
         unique case (ps_q)
            PS_UNSYNC: begin
               if (cmd_word == W_SYNC) begin
                  ps_d = PS_HEADER; // RL9
               end
            end
            PS_HEADER: begin
               if (cmd_word == W_HDR_WARM_ADDR) begin
                  ps_d = PS_ADDR_DATA; // RL13
               end else if (cmd_word == W_HDR_COMMAND) begin
                  ps_d = PS_CMD_DATA;
               end
            end
            PS_ADDR_DATA: begin
               ps_d = PS_HEADER;
            end
            PS_CMD_DATA: begin
               ps_d = (cmd_word == W_CMD_RELEASE_LINK) ? PS_UNSYNC : PS_HEADER;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ps_q <= PS_UNSYNC;
         addr_written_q <= 1'b0;
         warm_restart_address_reg <= IMAGE_ZERO_ADDR;
      end else begin
         ps_q <= ps_d;
         if (addr_take) begin
            warm_restart_address_reg <= cmd_word; // RL13
            addr_written_q <= 1'b1;
         end else if (cmd_valid && ps_q == PS_UNSYNC && cmd_word == W_SYNC) begin
            addr_written_q <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Load sequencer and fallback record
   // ---------------------------------------------------------------
   mbf_load_t ld_q;
   mbf_load_t ld_d;
   logic fallback_q;
   logic [31:0] good_addr_q;
   logic wd_expire;
   logic err_any;
   logic warm_go;
   logic loading;

   assign loading = (ld_q == LD_LOAD);
   assign err_any = loading && (id_mismatch || crc_error || auth_fail || wd_expire); // RL6
   assign warm_go = warm_cmd && (ld_q == LD_LOAD || ld_q == LD_USER);

   always_comb begin
      ld_d = ld_q;
      unique case (ld_q)
         LD_BOOT: begin
            ld_d = LD_LOAD;
         end
         LD_LOAD: begin
            if (warm_go) begin
               ld_d = LD_LOAD;
            end else if (err_any && fallback_q) begin
               ld_d = LD_FAILED; // RL23
            end else if (!err_any && load_done) begin
               ld_d = LD_USER;
            end
         end
         LD_USER: begin
            if (warm_go) begin
               ld_d = LD_LOAD;
            end
         end
         LD_FAILED: begin
            ld_d = LD_FAILED; // RL4
         end
         default: begin
            ld_d = LD_FAILED;
         end
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ld_q <= LD_BOOT;
         fallback_q <= 1'b0;
         good_addr_q <= IMAGE_ZERO_ADDR;
         load_addr_q <= IMAGE_ZERO_ADDR;
         load_start_q <= 1'b0;
         cfg_reset_q <= 1'b0;
         mem_clear_q <= 1'b0;
      end else begin
         ld_q <= ld_d;
         load_start_q <= 1'b0;
         cfg_reset_q <= 1'b0;
         mem_clear_q <= 1'b0;
         if (ld_q == LD_BOOT) begin
            load_addr_q <= IMAGE_ZERO_ADDR; // RL2
            load_start_q <= 1'b1;
         end else if (warm_go) begin
            load_addr_q <= warm_restart_address_reg; // RL7 RL11
            load_start_q <= 1'b1;
            fallback_q <= 1'b0;
            mem_clear_q <= !addr_written_q; // RL16
         end else if (err_any && !fallback_q) begin
            fallback_q <= 1'b1; // RL23
            cfg_reset_q <= 1'b1; // RL3
            load_addr_q <= good_addr_q; // RL8
            load_start_q <= 1'b1;
         end else if (loading && load_done && !err_any) begin
            good_addr_q <= load_addr_q;
         end
      end
   end

   assign flash_select_low = !loading; // RL4
   assign flash_clk = loading && sck;
   assign config_error_low = (ld_q != LD_FAILED); // RL4
   assign user_mode = (ld_q == LD_USER);
   assign fallback_active = fallback_q;

   // ---------------------------------------------------------------
   // Configuration watchdog
   // ---------------------------------------------------------------
   logic wd_active_q;
   logic [31:0] wd_cnt_q;
   logic wd_arm;

   // Armed only for a fresh load, never for a fallback load
   assign wd_arm = load_start_q && wd_enable && spi_master_mode && !fallback_q; // RL18 RL19
   // A stale count left from an ended or replaced load must not raise an error
   assign wd_expire = wd_active_q && cfg_tick && loading && !fallback_q && !wd_arm &&
                      (wd_cnt_q == WD_ONE);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wd_active_q <= 1'b0;
         wd_cnt_q <= WD_ZERO;
         wd_timeout_q <= 1'b0;
      end else begin
         if (wd_arm) begin
            wd_active_q <= 1'b1;
            wd_cnt_q <= wd_load_value; // RL24
            wd_timeout_q <= 1'b0;
         end else if (fallback_q || !loading) begin
            wd_active_q <= 1'b0; // RL19
         end else if (wd_active_q && cfg_tick) begin
            wd_cnt_q <= wd_cnt_q - WD_ONE; // RL17
            if (wd_cnt_q == WD_ONE) begin
               wd_timeout_q <= 1'b1; // RL17
               wd_active_q <= 1'b0;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   property p_clk_limit;
      @(posedge clk) disable iff (reset)
         per_eff >= (high_speed_mode ? PER_HIGH_MIN : PER_LOW_MIN);
   endproperty
   a_clk_limit: assert property (p_clk_limit) else $error("flash clock too fast"); // RL1

   property p_boot_addr;
      @(posedge clk) disable iff (reset)
         (ld_q == LD_BOOT) |=> load_start_q && (load_addr_q == IMAGE_ZERO_ADDR);
   endproperty
   a_boot_addr: assert property (p_boot_addr) else $error("boot not from zero"); // RL2

   property p_first_error;
      @(posedge clk) disable iff (reset)
         (err_any && !fallback_q && !warm_go) |=>
            cfg_reset_q && fallback_q && load_addr_q == $past(good_addr_q);
   endproperty
   a_first_error: assert property (p_first_error) else $error("fallback not started"); // RL3

   property p_second_error;
      @(posedge clk) disable iff (reset)
         (err_any && fallback_q && !warm_go) |=>
            (!config_error_low && flash_select_low && !cfg_reset_q) [*3];
   endproperty
   a_second_error: assert property (p_second_error) else $error("second failure not final"); // RL4

   property p_warm_addr;
      @(posedge clk) disable iff (reset)
         warm_go |=> load_start_q && load_addr_q == $past(warm_restart_address_reg) && !fallback_q;
   endproperty
   a_warm_addr: assert property (p_warm_addr) else $error("warm restart address wrong"); // RL7

   property p_sync;
      @(posedge clk) disable iff (reset)
         (ps_q == PS_UNSYNC && cmd_valid && cmd_word != W_SYNC) |=> ps_q == PS_UNSYNC;
   endproperty
   a_sync: assert property (p_sync) else $error("parsed before sync"); // RL9

   property p_addr_store;
      @(posedge clk) disable iff (reset)
         (ps_q == PS_HEADER && cmd_valid && cmd_word == W_HDR_WARM_ADDR) ##1 cmd_valid |=>
            warm_restart_address_reg == $past(cmd_word);
   endproperty
   a_addr_store: assert property (p_addr_store) else $error("address word not stored"); // RL13

   property p_mem_clear;
      @(posedge clk) disable iff (reset)
         warm_go |=> mem_clear_q == !$past(addr_written_q);
   endproperty
   a_mem_clear: assert property (p_mem_clear) else $error("memory clear wrong"); // RL16

   property p_wd_dec;
      @(posedge clk) disable iff (reset)
         (wd_active_q && cfg_tick && loading && !fallback_q && !wd_arm) |=>
            wd_cnt_q == $past(wd_cnt_q) - WD_ONE;
   endproperty
   a_wd_dec: assert property (p_wd_dec) else $error("watchdog not decrementing"); // RL17

   property p_wd_fallback;
      @(posedge clk) disable iff (reset)
         wd_expire && !fallback_q && !warm_go |=> fallback_q && cfg_reset_q;
   endproperty
   a_wd_fallback: assert property (p_wd_fallback) else $error("timeout ignored"); // RL18

   property p_wd_off;
      @(posedge clk) disable iff (reset)
         fallback_q |=> !wd_active_q || $past(warm_go);
   endproperty
   a_wd_off: assert property (p_wd_off) else $error("watchdog live in fallback"); // RL19
endmodule

// ===== logic/mbf_pkg.sv
// Constants shared by the multi-image boot loader and its clock divider
package mbf_pkg;
   // ---------------------------------------------------------------
   // Clock rates in kHz and derived divider periods
   // ---------------------------------------------------------------
   localparam int unsigned CLK_KHZ = 100000;
   localparam int unsigned CFG_DEFAULT_KHZ = 2990;
   localparam int unsigned CFG_LOW_MAX_KHZ = 15380;
   localparam int unsigned CFG_HIGH_MAX_KHZ = 40000;
   localparam int unsigned PER_W = 8;
   // Least periods round up so the clock never exceeds its ceiling
   localparam logic [7:0] PER_DEFAULT = 8'((CLK_KHZ + CFG_DEFAULT_KHZ - 1) / CFG_DEFAULT_KHZ);
   localparam logic [7:0] PER_LOW_MIN = 8'((CLK_KHZ + CFG_LOW_MAX_KHZ - 1) / CFG_LOW_MAX_KHZ);
   localparam logic [7:0] PER_HIGH_MIN = 8'((CLK_KHZ + CFG_HIGH_MAX_KHZ - 1) / CFG_HIGH_MAX_KHZ);
   localparam logic [7:0] PER_ZERO = 8'h00;

   // ---------------------------------------------------------------
   // Command stream words
   // ---------------------------------------------------------------
   localparam logic [31:0] W_SYNC = 32'h01332D94;
   localparam logic [31:0] W_HDR_WARM_ADDR = 32'hAC000001;
   localparam logic [31:0] W_HDR_COMMAND = 32'hA8800001;
   localparam logic [31:0] W_NO_OPERATION = 32'hA0000000;
   localparam logic [31:0] W_CMD_WARM_RESTART = 32'h0000000F;
   localparam logic [31:0] W_CMD_RELEASE_LINK = 32'h0000000B;

   // ---------------------------------------------------------------
   // Addresses and reset values
   // ---------------------------------------------------------------
   localparam logic [31:0] IMAGE_ZERO_ADDR = 32'h00000000;
   localparam logic [31:0] WD_ZERO = 32'h00000000;
   localparam logic [31:0] WD_ONE = 32'h00000001;

   // ---------------------------------------------------------------
   // State encodings
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      LD_BOOT = 3'h0,
      LD_LOAD = 3'h1,
      LD_USER = 3'h2,
      LD_FAILED = 3'h3
   } mbf_load_t;

   typedef enum logic [1:0] {
      PS_UNSYNC = 2'h0,
      PS_HEADER = 2'h1,
      PS_ADDR_DATA = 2'h2,
      PS_CMD_DATA = 2'h3
   } mbf_parse_t;
endpackage

// ===== logic/mbf_clkdiv.sv
// Programmable divider making the flash clock and its one-cycle tick
`timescale 1ns/100ps
module mbf_clkdiv
   import mbf_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Period in system cycles
   input wire logic [7:0] period,
   // Divided clock level and rising-edge enable
   output logic sck_q,
   output logic tick_q
);
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   logic wrap;

   assign wrap = (cnt_q >= period - 8'h01);
   assign cnt_d = wrap ? PER_ZERO : cnt_q + 8'h01;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt_q <= PER_ZERO;
         sck_q <= 1'b0;
         tick_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         sck_q <= (cnt_d < {1'b0, period[7:1]});
         tick_q <= wrap;
      end
   end
endmodule

// ===== dv/mbf_flash_model.sv
// Flash model answering each image load with done or a chosen error, except kind 3, which gives no answer
`timescale 1ns/100ps
module mbf_flash_model
   import mbf_pkg::*;
#(
   parameter int IMAGE_TICKS = 100
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Flash pins and load requests
   input wire logic flash_select_low,
   input wire logic flash_clk,
   input wire logic load_start,
   input wire logic [31:0] load_addr,
   // Fault setup
   input wire logic [31:0] bad_addr,
   input wire logic [1:0] bad_kind,
   input wire logic zero_bad,
   // Load outcome pulses
   output logic load_done,
   output logic id_mismatch,
   output logic crc_error,
   output logic auth_fail
);
   logic busy;
   logic sck_prev;
   logic fail;
   int ticks;

   // Image zero at address 0 may be marked broken as well
   assign fail = load_addr == bad_addr || (zero_bad && load_addr == IMAGE_ZERO_ADDR);

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         {busy, sck_prev, load_done, id_mismatch, crc_error, auth_fail} <= 6'h00;
         ticks <= 0;
      end else begin
         sck_prev <= flash_clk;
         {load_done, id_mismatch, crc_error, auth_fail} <= 4'h0;
         if (load_start) begin
            busy <= 1'b1;
            ticks <= 0;
         end else if (busy && !flash_select_low && flash_clk && !sck_prev) begin
            ticks <= ticks + 1;
            if (ticks == IMAGE_TICKS - 1) begin
               busy <= 1'b0;
               // Kind 3 never answers, so only the watchdog ends that load
               if (!fail)
                  load_done <= 1'b1;
               else
                  {auth_fail, crc_error, id_mismatch} <= 3'(4'h1 << bad_kind);
            end
         end
      end
   end
endmodule

// ===== dv/tb.sv
// Self-checking bench for the multi-image boot loader
`timescale 1ns/100ps
module tb
   import mbf_pkg::*;
;
   localparam logic [31:0] APP = 32'h00040000;
   localparam logic [31:0] BAD = 32'h00080000;
   localparam logic [7:0] PT [4] = '{8'h00, 8'h02, 8'h02, 8'h05};
   localparam logic HS [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
   localparam logic [7:0] EXP [4] = '{8'h22, 8'h03, 8'h07, 8'h05};
   logic clk, reset, high_speed_mode, spi_master_mode, wd_enable, cmd_valid, zero_bad;
   logic load_done, id_mismatch, crc_error, auth_fail, flash_select_low, flash_clk;
   logic load_start_q, cfg_reset_q, mem_clear_q, config_error_low, user_mode;
   logic fallback_active, wd_timeout_q, ls_clear, ls_fb;
   logic [7:0] cfg_clk_period;
   logic [1:0] bad_kind;
   logic [31:0] wd_load_value, cmd_word, bad_addr, load_addr_q, warm_restart_address_reg, ls_addr;
   int error_cnt, n_compared, cyc, ls_cnt, cr_cnt, t_ls, t_prev, t_wd, per;

   mbf_loader mbf_loader_inst (.clk, .reset, .high_speed_mode, .cfg_clk_period,
      .spi_master_mode, .wd_enable, .wd_load_value, .cmd_valid, .cmd_word, .load_done,
      .id_mismatch, .crc_error, .auth_fail, .flash_select_low, .flash_clk, .load_start_q,
      .load_addr_q, .cfg_reset_q, .mem_clear_q, .config_error_low, .user_mode,
      .fallback_active, .wd_timeout_q, .warm_restart_address_reg);

   mbf_flash_model mbf_flash_model_inst (.clk, .reset, .flash_select_low, .flash_clk,
      .load_start(load_start_q), .load_addr(load_addr_q), .bad_addr, .bad_kind, .zero_bad,
      .load_done, .id_mismatch, .crc_error, .auth_fail);

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Records every load start, reset pulse and watchdog flag rise
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (load_start_q) begin
         ls_cnt <= ls_cnt + 1;
         ls_addr <= load_addr_q;
         ls_clear <= mem_clear_q;
         ls_fb <= fallback_active;
         t_ls <= cyc;
         t_prev <= t_ls;
      end
      if (cfg_reset_q)
         cr_cnt <= cr_cnt + 1;
      if ($rose(wd_timeout_q))
         t_wd <= cyc;
      if (cyc == 40000) begin
         error_cnt++;
         test_done();
      end
   end

   task automatic test_done();
      $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic send(input logic [31:0] w);
      @(posedge clk);
      #1;
      cmd_valid = 1'b1;
      cmd_word = w;
   endtask

   task automatic warm(input logic [31:0] a, input logic wa);
      repeat (100) send(32'hFFFFFFFF);
      send(32'h000000AA);
      send(32'h08100020);
      repeat (10) send(32'hFFFFFFFF);
      send(W_SYNC);
      if (wa) begin
         send(W_HDR_WARM_ADDR);
         send(a);
      end
      send(W_HDR_COMMAND);
      send(W_CMD_WARM_RESTART);
      send(W_HDR_COMMAND);
      send(W_CMD_RELEASE_LINK);
      repeat (100) send(W_NO_OPERATION);
      @(posedge clk);
      #1;
      cmd_valid = 1'b0;
   endtask

   task automatic wait_starts(input int n);
      for (int i = 0; i < 5000 && ls_cnt < n; i++)
         @(posedge clk);
      #1;
      check(ls_cnt, n);
   endtask

   task automatic wait_user();
      for (int i = 0; i < 5000 && user_mode !== 1'b1; i++)
         @(posedge clk);
      #1;
      check(user_mode, 1'b1);
   endtask

   task automatic wait_failed();
      for (int i = 0; i < 2000 && config_error_low !== 1'b0; i++)
         @(posedge clk);
      #1;
      check(config_error_low, 1'b0);
   endtask

   // Flash clock period in system cycles, skipping the first edges
   task automatic measure(output int p);
      int t0;
      repeat (2) @(posedge flash_clk);
      #1;
      t0 = cyc;
      @(posedge flash_clk);
      #1;
      p = cyc - t0;
   endtask

   initial begin
      int n0, c0;
      reset = 1'b1;
      {high_speed_mode, cmd_valid, zero_bad} = 3'h0;
      spi_master_mode = 1'b1;
      wd_enable = 1'b1;
      wd_load_value = 32'h00000078;
      cfg_clk_period = 8'h00;
      cmd_word = 32'h00000000;
      bad_addr = BAD;
      bad_kind = 2'h1;
      repeat (4) @(posedge clk);
      #1;
      reset = 1'b0;
      wait_starts(1);
      check(ls_addr, IMAGE_ZERO_ADDR);
      check(flash_select_low, 1'b0);
      wait_user();
      // Command words without the sync word must not restart
      send(W_HDR_COMMAND);
      send(W_CMD_WARM_RESTART);
      repeat (4) @(posedge clk);
      #1;
      check(ls_cnt, 1);
      for (int k = 0; k < 4; k++) begin
         cfg_clk_period = PT[k];
         high_speed_mode = HS[k];
         warm(APP, 1'b1);
         wait_starts(k + 2);
         check(ls_addr, APP);
         check(warm_restart_address_reg, APP);
         check(ls_clear, 1'b0);
         measure(per);
         check(per, 32'(EXP[k]));
         wait_user();
      end
      warm(BAD, 1'b0);
      wait_starts(6);
      check(ls_clear, 1'b1);
      check(ls_addr, APP);
      wait_user();
      // One fallback per error kind; kind 3 hangs until the watchdog fires
      for (int k = 0; k < 4; k++) begin
         bad_kind = 2'(k);
         n0 = ls_cnt;
         c0 = cr_cnt;
         warm(BAD, 1'b1);
         wd_load_value = 32'h00000001;
         check(ls_fb, 1'b0);
         wait_starts(n0 + 2);
         check(ls_addr, APP);
         check(ls_fb, 1'b1);
         check(cr_cnt, c0 + 1);
         wait_user();
         check(wd_timeout_q, k == 3);
         if (k == 3)
            check((t_wd - t_prev) inside {[596:606]}, 1'b1);
         wd_load_value = 32'h00000078;
      end
      // Application image and its fallback target both broken
      bad_addr = APP;
      bad_kind = 2'h1;
      n0 = ls_cnt;
      c0 = cr_cnt;
      warm(APP, 1'b1);
      wait_starts(n0 + 2);
      check(ls_addr, APP);
      wait_failed();
      check(flash_select_low, 1'b1);
      check(cr_cnt, c0 + 1);
      warm(APP, 1'b1);
      check(ls_cnt, n0 + 2);
      check(flash_select_low, 1'b1);
      // Reset with a broken image zero falls back to address 0 and fails
      zero_bad = 1'b1;
      reset = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      reset = 1'b0;
      wait_starts(n0 + 4);
      check(ls_addr, IMAGE_ZERO_ADDR);
      check(ls_fb, 1'b1);
      wait_failed();
      // A clean reset starts over from image zero
      reset = 1'b1;
      zero_bad = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      reset = 1'b0;
      wait_starts(n0 + 5);
      check(ls_addr, IMAGE_ZERO_ADDR);
      check(config_error_low, 1'b1);
      test_done();
   end
endmodule
